//--- core/epwp_top.sv
// serial-clock front end and core-clock protection logic of the partition write-protect block
//
// Overview of operation
// - opcode 83h plus 16-bit address with A10 set queries lock
// - reply byte bit 0 shows ID page lock
// - status byte 1 bit 7 selects mode
// - mode bit changes only by status write
// - freeze makes current mode permanent
// - legacy mode protects by block bits
// - enhanced, pin enable, pin asserted block config
// - four limit registers, up to four partitions
// - bits 5:0 are endpoint A11:A6, low ones
// - legacy mode ignores limit registers
// - top two bits choose partition behaviour
// - eight-bit limit registers kept nonvolatile; here reset reloads them with LIM_INIT
// - non-increasing later endpoint is ignored
// - behaviour 11b locks register for good
// - 00 open, 01 soft, 10 pin, 11 locked
// - partition starts after previous endpoint, first 0
// - address bits 11:10 select limit register
// - write enable then unlock; both cleared after
`timescale 1ns/1ns

// ************************************************************
// frame shifter, cleared whenever chip select is high
// ************************************************************
module epwp_frame (
  // serial link
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_n_o,
  // to the persistent link side
  input wire logic lock_i,
  output logic pub_o,
  output logic [31:0] full_o,
  output logic [7:0] op_o
);
  localparam int CNT_W_L = epwp_pkg::CNT_W;
  epwp_pkg::epwp_frame_t q, d;
  logic [CNT_W_L-1:0] len;

  always_comb begin
    d = q;
    full_o = {q.sh[30:0], si_i};
    op_o = (q.cnt < epwp_pkg::BYTE_BITS) ? full_o[7:0] : q.op;
    len = epwp_pkg::frame_len(op_o);
    // publish on the very edge that completes the frame; no later edge is guaranteed
    pub_o = (len != epwp_pkg::LEN_NONE) && (q.cnt == len - 6'd1);
    d.sh = full_o;
    if (q.cnt != epwp_pkg::CNT_MAX) begin
      d.cnt = q.cnt + 6'd1;
    end
    if (q.cnt == epwp_pkg::BYTE_BITS - 6'd1) begin
      d.op = full_o[7:0];
    end
    if (q.tx_en) begin
      d.tx = {q.tx[6:0], 1'b0};
    end
    if ((q.cnt == epwp_pkg::QUERY_LAST) && (q.op == epwp_pkg::OP_LOCK_QUERY)
        && full_o[epwp_pkg::QUERY_FLAG_BIT]) begin
      d.tx = {7'h00, lock_i};
      d.tx_en = 1'b1;
    end
  end

  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign so_o = q.tx[7];
  assign so_oe_n_o = ~q.tx_en;
endmodule // epwp_frame

// ************************************************************
// persistent serial-clock state: command hand-off and lock sync
// ************************************************************
module epwp_link (
  // clock and reset
  input wire logic sck_i,
  input wire logic rst_i,
  // from the frame shifter
  input wire logic pub_i,
  input wire logic [31:0] full_i,
  input wire logic [7:0] op_i,
  // crossings
  input wire logic lock_i,
  output logic lock_o,
  output logic tgl_o,
  output logic [31:0] word_o,
  output logic [7:0] op_o
);
  epwp_pkg::epwp_link_t q, d;

  always_comb begin
    d = q;
    d.lk_s1 = lock_i;
    d.lk_s2 = q.lk_s1;
    // word and opcode stay put until the next complete frame, long after the core took them
    if (pub_i) begin
      d.tgl = ~q.tgl;
      d.word = full_i;
      d.op = op_i;
    end
  end

  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lock_o = q.lk_s2;
  assign tgl_o = q.tgl;
  assign word_o = q.word;
  assign op_o = q.op;
endmodule // epwp_link

// ************************************************************
// top: core-clock registers and protection decision
// ************************************************************
module epwp_top #(
  parameter int ADDR_W = epwp_pkg::ADDR_W,
  parameter logic [7:0] LIM_INIT = epwp_pkg::LIM_RESET
) (
  // core clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // serial link
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_n_o,
  // write protect pin, active low
  input wire logic wp_n_i,
  // ID page lock state from the security page logic
  input wire logic id_page_locked_i,
  // array write request
  output logic arr_wr_o,
  output logic arr_drop_o,
  output logic [ADDR_W-1:0] arr_addr_o,
  output logic [7:0] arr_data_o,
  // configuration state
  output logic protection_mode_select_o,
  output logic pin_protect_enable_o,
  output logic [1:0] block_protect_o,
  output logic frozen_o,
  output logic write_enable_latch_o,
  output logic partition_unlock_latch_o,
  output logic sec_page_wp_o,
  output logic [7:0] undervoltage_lockout_o,
  output logic [7:0] partition_limit_0_o,
  output logic [7:0] partition_limit_1_o,
  output logic [7:0] partition_limit_2_o,
  output logic [7:0] partition_limit_3_o
);
  localparam int NP = epwp_pkg::N_PART;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic wp_s1;
    logic wp_s2;
    logic tg_s1;
    logic tg_s2;
    logic tg_s3;
    logic pend;
    logic [7:0] op;
    logic [31:0] word;
    logic write_enable_latch;
    logic partition_unlock_latch;
    logic protection_mode_select;
    logic pin_protect_enable;
    logic [1:0] bp;
    logic frozen;
    logic [NP-1:0][7:0] lim;
    logic [7:0] undervoltage_lockout_register;
    logic wr;
    logic drop;
    logic [ADDR_W-1:0] waddr;
    logic [7:0] wdata;
    logic sec_wp;
  } epwp_core_t;

  epwp_core_t q, d;
  logic pub, tgl, lock_x;
  logic [31:0] full, word_x;
  logic [7:0] fop, op_x;
  logic evt, exec, wp_act, cfg_block, prot;
  logic [ADDR_W-1:0] addr;
  logic [7:0] data;
  logic [1:0] sel;

  epwp_frame u_frame (
    .sck_i(sck_i),
    .cs_n_i(cs_n_i),
    .si_i(si_i),
    .so_o(so_o),
    .so_oe_n_o(so_oe_n_o),
    .lock_i(lock_x),
    .pub_o(pub),
    .full_o(full),
    .op_o(fop)
  );

  epwp_link u_link (
    .sck_i(sck_i),
    .rst_i(rst_i),
    .pub_i(pub),
    .full_i(full),
    .op_i(fop),
    .lock_i(id_page_locked_i),
    .lock_o(lock_x),
    .tgl_o(tgl),
    .word_o(word_x),
    .op_o(op_x)
  );

  typedef epwp_pkg::epwp_behav_t epwp_behav_t;

  // returns one when an array address may not be written
  function automatic logic is_protected(input logic [ADDR_W-1:0] a, input logic [NP-1:0][7:0] lim,
                                        input logic mode, input logic [1:0] bp, input logic pin);
    logic [ADDR_W:0] start;
    logic [ADDR_W-1:0] endp;
    logic res;
    start = '0;
    res = 1'b0;
    if (!mode) begin
      case (bp)
        epwp_pkg::BP_QUARTER: res = (a[ADDR_W-1 -: 2] == 2'b11);
        epwp_pkg::BP_HALF: res = a[ADDR_W-1];
        epwp_pkg::BP_ALL: res = 1'b1;
        default: res = 1'b0;
      endcase
    end else begin
      // beyond the last accepted endpoint nothing matches and res stays clear
      for (int i = 0; i < NP; i++) begin
        endp = {lim[i][epwp_pkg::ENDPT_HI:0], epwp_pkg::ENDPT_FILL};
        if ({1'b0, endp} >= start) begin
          if (({1'b0, a} >= start) && (a <= endp)) begin
            case (epwp_behav_t'(lim[i][epwp_pkg::BEH_HI:epwp_pkg::BEH_LO]))
              epwp_pkg::BEH_SOFT, epwp_pkg::BEH_LOCKED: res = 1'b1;
              epwp_pkg::BEH_PIN: res = pin;
              default: res = 1'b0;
            endcase
          end
          start = {1'b0, endp} + {{ADDR_W{1'b0}}, 1'b1};
        end
      end
    end
    return res;
  endfunction

  always_comb begin
    d = q;
    d.wr = 1'b0;
    d.drop = 1'b0;
    d.cs_s1 = cs_n_i;
    d.cs_s2 = q.cs_s1;
    d.wp_s1 = wp_n_i;
    d.wp_s2 = q.wp_s1;
    d.tg_s1 = tgl;
    d.tg_s2 = q.tg_s1;
    d.tg_s3 = q.tg_s2;
    wp_act = ~q.wp_s2;
    evt = q.tg_s2 ^ q.tg_s3;
    // a command runs only once its frame has closed
    exec = q.pend && q.cs_s2 && !evt;
    addr = q.word[epwp_pkg::ADDR_LO +: ADDR_W];
    data = q.word[7:0];
    sel = q.word[epwp_pkg::SEL_HI:epwp_pkg::SEL_LO];
    cfg_block = q.protection_mode_select && q.pin_protect_enable && wp_act;
    prot = is_protected(addr, q.lim, q.protection_mode_select, q.bp, wp_act);
    if (evt) begin
      d.pend = 1'b1;
      d.word = word_x;
      d.op = op_x;
    end else if (exec) begin
      d.pend = 1'b0;
      case (q.op)
        epwp_pkg::OP_WRITE_ENABLE: begin
          d.write_enable_latch = 1'b1;
        end
        epwp_pkg::OP_PART_UNLOCK: begin
          d.partition_unlock_latch = q.write_enable_latch;
        end
        epwp_pkg::OP_STATUS_WRITE: begin
          if (q.write_enable_latch && !cfg_block) begin
            d.pin_protect_enable = q.word[epwp_pkg::STS0_LO + epwp_pkg::PIN_EN_BIT];
            d.bp = q.word[epwp_pkg::STS0_LO + epwp_pkg::BP_HI : epwp_pkg::STS0_LO + epwp_pkg::BP_LO];
            if (!q.frozen) begin
              d.protection_mode_select = q.word[epwp_pkg::MODE_BIT];
            end
          end
          d.write_enable_latch = 1'b0;
        end
        epwp_pkg::OP_LIMIT_WRITE: begin
          if (q.write_enable_latch && q.partition_unlock_latch && !cfg_block && !q.frozen
              && (q.lim[sel][epwp_pkg::BEH_HI:epwp_pkg::BEH_LO] != epwp_pkg::BEH_LOCKED)) begin
            d.lim[sel] = data;
          end
          d.write_enable_latch = 1'b0;
          d.partition_unlock_latch = 1'b0;
        end
        epwp_pkg::OP_FREEZE: begin
          if (q.write_enable_latch && q.partition_unlock_latch && !cfg_block) begin
            d.frozen = 1'b1;
          end
          d.write_enable_latch = 1'b0;
          d.partition_unlock_latch = 1'b0;
        end
        epwp_pkg::OP_UNDERVOLTAGE_LOCKOUT_REGISTER_WRITE: begin
          if (q.write_enable_latch && !cfg_block) begin
            d.undervoltage_lockout_register = data;
          end
          d.write_enable_latch = 1'b0;
        end
        epwp_pkg::OP_ARRAY_WRITE: begin
          if (q.write_enable_latch) begin
            d.waddr = addr;
            d.wdata = data;
            d.wr = !prot;
            d.drop = prot;
          end
          d.write_enable_latch = 1'b0;
        end
        default: begin
        end
      endcase
    end
    d.sec_wp = !q.protection_mode_select && (q.bp == epwp_pkg::BP_ALL);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.cs_s1 <= 1'b1;
      q.cs_s2 <= 1'b1;
      q.wp_s1 <= 1'b1;
      q.wp_s2 <= 1'b1;
      q.lim <= {NP{LIM_INIT}};
      q.undervoltage_lockout_register <= epwp_pkg::UNDERVOLTAGE_LOCKOUT_REGISTER_RESET;
    end else begin
      q <= d;
    end
  end

  assign arr_wr_o = q.wr;
  assign arr_drop_o = q.drop;
  assign arr_addr_o = q.waddr;
  assign arr_data_o = q.wdata;
  assign protection_mode_select_o = q.protection_mode_select;
  assign pin_protect_enable_o = q.pin_protect_enable;
  assign block_protect_o = q.bp;
  assign frozen_o = q.frozen;
  assign write_enable_latch_o = q.write_enable_latch;
  assign partition_unlock_latch_o = q.partition_unlock_latch;
  assign sec_page_wp_o = q.sec_wp;
  assign undervoltage_lockout_o = q.undervoltage_lockout_register;
  assign partition_limit_0_o = q.lim[0];
  assign partition_limit_1_o = q.lim[1];
  assign partition_limit_2_o = q.lim[2];
  assign partition_limit_3_o = q.lim[3];
endmodule // epwp_top

//--- core/epwp_pkg.sv
// constants, types and helpers shared by the partition write-protect block
package epwp_pkg;

  // ************************************************************
  // geometry
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam int N_PART = 4;
  localparam int CNT_W = 6;
  localparam logic [5:0] ENDPT_FILL = 6'h3f;
  localparam logic [7:0] LIM_RESET = 8'h00;
  localparam logic [7:0] UNDERVOLTAGE_LOCKOUT_REGISTER_RESET = 8'h00;

  // ************************************************************
  // opcodes
  // ************************************************************
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_PART_UNLOCK = 8'h07;
  localparam logic [7:0] OP_LOCK_QUERY = 8'h83;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
  localparam logic [7:0] OP_LIMIT_WRITE = 8'h32;
  localparam logic [7:0] OP_FREEZE = 8'h35;
  localparam logic [7:0] OP_UNDERVOLTAGE_LOCKOUT_REGISTER_WRITE = 8'h3a;

  // ************************************************************
  // frame lengths in serial bits
  // ************************************************************
  localparam logic [CNT_W-1:0] BYTE_BITS = 6'd8;
  localparam logic [CNT_W-1:0] LEN_NONE = 6'd0;
  localparam logic [CNT_W-1:0] LEN_OPCODE = 6'd8;
  localparam logic [CNT_W-1:0] LEN_UNDERVOLTAGE_LOCKOUT_REGISTER = 6'd16;
  localparam logic [CNT_W-1:0] LEN_STATUS = 6'd24;
  localparam logic [CNT_W-1:0] LEN_ADDR_DATA = 6'd32;
  localparam logic [CNT_W-1:0] QUERY_LAST = 6'd23;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;

  // ************************************************************
  // field positions inside a captured frame word
  // ************************************************************
  localparam int QUERY_FLAG_BIT = 10;
  localparam int ADDR_LO = 8;
  localparam int SEL_HI = ADDR_LO + 11;
  localparam int SEL_LO = ADDR_LO + 10;
  localparam int STS0_LO = 8;
  localparam int PIN_EN_BIT = 7;
  localparam int BP_HI = 3;
  localparam int BP_LO = 2;
  localparam int MODE_BIT = 7;
  localparam int BEH_HI = 7;
  localparam int BEH_LO = 6;
  localparam int ENDPT_HI = 5;

  localparam logic [1:0] BP_NONE = 2'b00;
  localparam logic [1:0] BP_QUARTER = 2'b01;
  localparam logic [1:0] BP_HALF = 2'b10;
  localparam logic [1:0] BP_ALL = 2'b11;

  typedef enum logic [1:0] {
    BEH_OPEN = 2'b00,
    BEH_SOFT = 2'b01,
    BEH_PIN = 2'b10,
    BEH_LOCKED = 2'b11
  } epwp_behav_t;

  // ************************************************************
  // state records
  // ************************************************************
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [31:0] sh;
    logic [7:0] op;
    logic [7:0] tx;
    logic tx_en;
  } epwp_frame_t;

  typedef struct packed {
    logic tgl;
    logic [31:0] word;
    logic [7:0] op;
    logic lk_s1;
    logic lk_s2;
  } epwp_link_t;

  function automatic logic [CNT_W-1:0] frame_len(input logic [7:0] op);
    case (op)
      OP_WRITE_ENABLE, OP_PART_UNLOCK, OP_FREEZE: frame_len = LEN_OPCODE;
      OP_UNDERVOLTAGE_LOCKOUT_REGISTER_WRITE: frame_len = LEN_UNDERVOLTAGE_LOCKOUT_REGISTER;
      OP_STATUS_WRITE: frame_len = LEN_STATUS;
      OP_ARRAY_WRITE, OP_LIMIT_WRITE: frame_len = LEN_ADDR_DATA;
      default: frame_len = LEN_NONE;
    endcase
  endfunction

endpackage

//--- test/epwp_checker.sv
// assertion checker for the partition write-protect block
`timescale 1ns/1ns

// ************************************************************
// checker
// ************************************************************
module epwp_checker (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // pins
  input wire logic cs_n_i,
  input wire logic wp_n_i,
  input wire logic so_oe_n_o,
  // array write outcome
  input wire logic arr_wr_o,
  input wire logic arr_drop_o,
  // configuration state
  input wire logic protection_mode_select_o,
  input wire logic pin_protect_enable_o,
  input wire logic [1:0] block_protect_o,
  input wire logic frozen_o,
  input wire logic write_enable_latch_o,
  input wire logic partition_unlock_latch_o,
  input wire logic sec_page_wp_o,
  input wire logic [7:0] undervoltage_lockout_o,
  input wire logic [7:0] partition_limit_1_o,
  input wire logic [7:0] partition_limit_2_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  so_idle_a: assert property (cs_n_i |-> so_oe_n_o)
    else $error("so enabled while deselected");
  one_pulse_a: assert property ((arr_wr_o || arr_drop_o) |-> !(arr_wr_o && arr_drop_o) ##1 !(arr_wr_o || arr_drop_o))
    else $error("array outcome not a single pulse");
  legacy_all_a: assert property (!protection_mode_select_o && block_protect_o == 2'b11 |-> !arr_wr_o)
    else $error("array write in fully protected legacy mode");
  sec_on_a: assert property ((!protection_mode_select_o && block_protect_o == 2'b11) [*2] |-> sec_page_wp_o)
    else $error("security page not protected");
  sec_off_a: assert property ((protection_mode_select_o || block_protect_o != 2'b11) [*2] |-> !sec_page_wp_o)
    else $error("security page protected wrongly");
  lock_hold_a: assert property (partition_limit_1_o[7:6] == 2'b11 |=> $stable(partition_limit_1_o))
    else $error("locked limit register changed");
  freeze_hold_a: assert property (frozen_o |=> frozen_o && $stable(protection_mode_select_o))
    else $error("mode changed after freeze");
  latch_pair_a: assert property (partition_unlock_latch_o |-> write_enable_latch_o)
    else $error("unlock latch without write enable");
  lim_cause_a: assert property ($changed(partition_limit_2_o) |-> $past(partition_unlock_latch_o) && !partition_unlock_latch_o)
    else $error("limit update without unlock");
  mode_cause_a: assert property ($changed(protection_mode_select_o) |-> $past(write_enable_latch_o))
    else $error("mode changed without enabled write");
  pin_block_a: assert property ((protection_mode_select_o && pin_protect_enable_o && !wp_n_i) [*8] |=> $stable(undervoltage_lockout_o))
    else $error("config changed while pin protected");

  cover property (arr_drop_o);
  cover property ($rose(frozen_o));
  cover property (!so_oe_n_o);
endmodule // epwp_checker

bind epwp_top epwp_checker chk_i (.core_clk_i, .rst_i, .cs_n_i, .wp_n_i, .so_oe_n_o, .arr_wr_o, .arr_drop_o,
  .protection_mode_select_o, .pin_protect_enable_o, .block_protect_o, .frozen_o, .write_enable_latch_o,
  .partition_unlock_latch_o, .sec_page_wp_o, .undervoltage_lockout_o, .partition_limit_1_o, .partition_limit_2_o);

//--- test/epwp_host.sv
// host serial master model for the partition write-protect block
`timescale 1ns/1ns

// ************************************************************
// host
// ************************************************************
module epwp_host (
  // serial link
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_n_i
);
  logic [7:0] rx;
  logic oe_seen;

  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    rx = 8'h00;
    oe_seen = 1'b0;
  end

  // mode 0, msb first; sck stands low outside frames
  task automatic xfer(input logic [31:0] w, input int n);
    oe_seen = 1'b0;
    #3 cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      si_o = w[31-i];
      #32 sck_o = 1'b1;
      #32 sck_o = 1'b0;
      rx = {rx[6:0], so_i};
      oe_seen = oe_seen | ~so_oe_n_i;
    end
    #16 cs_n_o = 1'b1;
    // released line must not keep a stale level
    si_o = ~si_o;
    #120;
  endtask
endmodule // epwp_host

//--- test/tb.sv
// self-checking bench for the partition write-protect block
`timescale 1ns/1ns

module tb;
  logic core_clk_i, rst_i, sck_i, cs_n_i, si_i, so_o, so_oe_n_o, wp_n_i, id_page_locked_i;
  logic arr_wr_o, arr_drop_o, protection_mode_select_o, pin_protect_enable_o, frozen_o;
  logic write_enable_latch_o, partition_unlock_latch_o, sec_page_wp_o;
  logic [1:0] block_protect_o;
  logic [7:0] undervoltage_lockout_o, partition_limit_0_o, partition_limit_1_o, arr_data_o;
  logic [11:0] arr_addr_o;
  logic [7:0] partition_limit_2_o, partition_limit_3_o;
  wire [31:0] lims = {partition_limit_3_o, partition_limit_2_o, partition_limit_1_o, partition_limit_0_o};
  int miscompares, samples_checked, nwr, ndrop;
  logic [7:0] lv [4] = '{8'h1f, 8'h41, 8'h43, 8'ha0};
  logic [16:0] tv [6] = '{{1'b1, 16'h0000}, {1'b1, 16'h0090}, {1'b1, 16'h0800},
                          {1'b0, 16'h0800}, {1'b0, 16'h083f}, {1'b0, 16'h0840}};
  logic te [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

  epwp_top uut (.core_clk_i, .rst_i, .sck_i, .cs_n_i, .si_i, .so_o, .so_oe_n_o, .wp_n_i, .id_page_locked_i,
    .arr_wr_o, .arr_drop_o, .arr_addr_o, .arr_data_o, .protection_mode_select_o, .pin_protect_enable_o,
    .block_protect_o, .frozen_o, .write_enable_latch_o, .partition_unlock_latch_o, .sec_page_wp_o,
    .undervoltage_lockout_o, .partition_limit_0_o, .partition_limit_1_o, .partition_limit_2_o,
    .partition_limit_3_o);
  epwp_host host (.sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i), .so_i(so_o), .so_oe_n_i(so_oe_n_o));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    if (arr_wr_o === 1'b1) nwr++;
    if (arr_drop_o === 1'b1) ndrop++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic edge1;
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic cmd(input logic [7:0] op);
    host.xfer({op, 24'h0}, 8);
  endtask
  task automatic lim(input logic [1:0] n, input logic [7:0] d);
    cmd(8'h06);
    cmd(8'h07);
    host.xfer({8'h32, 4'h0, n, 10'h000, d}, 32);
  endtask
  task automatic sts(input logic [7:0] b0, input logic [7:0] b1);
    cmd(8'h06);
    host.xfer({8'h01, b0, b1, 8'h00}, 24);
  endtask
  task automatic arr(input logic [15:0] a, input logic ew);
    int w0, d0;
    w0 = nwr;
    d0 = ndrop;
    cmd(8'h06);
    host.xfer({8'h02, a, 8'h5a}, 32);
    chk(8'(nwr - w0), {7'h0, ew});
    chk(8'(ndrop - d0), {7'h0, ~ew});
    chk(arr_data_o, 8'h5a);
    chk(arr_addr_o[7:0], a[7:0]);
    chk({4'h0, arr_addr_o[11:8]}, {4'h0, a[11:8]});
  endtask
  task automatic undervoltage_lockout_register(input logic [7:0] d);
    cmd(8'h06);
    host.xfer({8'h3a, d, 16'h0}, 16);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #200_000;
    miscompares++;
    test_done;
  end

  initial begin
    rst_i = 1'b1;
    wp_n_i = 1'b1;
    id_page_locked_i = 1'b1;
    miscompares = 0;
    samples_checked = 0;
    nwr = 0;
    ndrop = 0;
    repeat (12) edge1;
    rst_i = 1'b0;
    repeat (3) edge1;
    chk(lims[7:0], 8'h00);
    chk({7'h0, protection_mode_select_o}, 8'h00);
    // ****************** lock query ******************
    host.xfer({8'h83, 16'h0400, 8'h00}, 31);
    chk({7'h0, host.rx[0]}, 8'h01);
    edge1;
    id_page_locked_i = 1'b0;
    host.xfer({8'h83, 16'hffff, 8'h00}, 31);
    chk({7'h0, host.rx[0]}, 8'h00);
    host.xfer({8'h83, 16'hfbff, 8'h00}, 31);
    chk({7'h0, host.oe_seen}, 8'h00);
    // ****************** limit registers ******************
    cmd(8'h07);
    chk({7'h0, partition_unlock_latch_o}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      lim(2'(i), lv[i]);
      chk(lims[i*8 +: 8], lv[i]);
    end
    chk({6'h0, write_enable_latch_o, partition_unlock_latch_o}, 8'h00);
    arr(16'h0840, 1'b1);
    // ****************** enhanced partitions ******************
    sts(8'h00, 8'h80);
    chk({7'h0, protection_mode_select_o}, 8'h01);
    host.xfer({8'h01, 24'h0}, 24);
    chk({7'h0, protection_mode_select_o}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      edge1;
      wp_n_i = tv[i][16];
      arr(tv[i][15:0], te[i]);
    end
    lim(2'd0, 8'h5f);
    arr(16'h0000, 1'b0);
    lim(2'd3, 8'h20);
    arr(16'h0800, 1'b1);
    lim(2'd1, 8'hc1);
    lim(2'd1, 8'h00);
    chk(partition_limit_1_o, 8'hc1);
    // ****************** pin protect ******************
    sts(8'h80, 8'h80);
    undervoltage_lockout_register(8'h55);
    chk(undervoltage_lockout_o, 8'h00);
    edge1;
    wp_n_i = 1'b1;
    undervoltage_lockout_register(8'h55);
    chk(undervoltage_lockout_o, 8'h55);
    // ****************** legacy and freeze ******************
    sts(8'h0c, 8'h00);
    chk({7'h0, sec_page_wp_o}, 8'h01);
    arr(16'h0840, 1'b0);
    sts(8'h00, 8'h00);
    arr(16'h0000, 1'b1);
    sts(8'h00, 8'h80);
    cmd(8'h06);
    cmd(8'h07);
    cmd(8'h35);
    chk({7'h0, frozen_o}, 8'h01);
    sts(8'h00, 8'h00);
    chk({7'h0, protection_mode_select_o}, 8'h01);
    test_done;
  end
endmodule // tb
